// ===== hdl/mds_pkg.sv
`default_nettype none

package mds_pkg;

  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte addresses
  localparam logic [7:0] STATUS_ADDR = 8'h00;
  localparam logic [7:0] CTRL_ADDR = 8'h04;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h08;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h0c;

  // Status word field positions
  localparam int STST_BIT = 31;
  localparam int OLB_BIT = 30;
  localparam int OLA_BIT = 29;
  localparam int SGB_BIT = 28;
  localparam int SGA_BIT = 27;
  localparam int OTPW_BIT = 26;
  localparam int OT_BIT = 25;
  localparam int STALL_BIT = 24;
  localparam int CS_LSB = 16;
  localparam int CS_W = 5;
  localparam int LOAD_W = 10;

  // Control register fields
  localparam int CHOPPER_TIMING_SETTING_LSB = 0;
  localparam int CHOPPER_TIMING_SETTING_W = 4;
  localparam int LSM_BIT = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Interrupt event bits
  localparam int IRQ_W = 8;
  localparam int EV_STST = 0;
  localparam int EV_OLA = 1;
  localparam int EV_OLB = 2;
  localparam int EV_SGA = 3;
  localparam int EV_SGB = 4;
  localparam int EV_OTPW = 5;
  localparam int EV_OT = 6;
  localparam int EV_STALL = 7;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

  // Standstill delay, counted in core clocks
  localparam int STANDSTILL_CLOCKS = 2 ** 20;
  localparam int CLK_MHZ = 100;

endpackage : mds_pkg

`default_nettype wire

// ===== hdl/mds_status_flags.sv
// Contract
// - Standstill flag after 2^20 clocks without step
// - Open-load flag per phase
// - Open-load never touches bridge operation
// - Short to ground sets flag, disables bridges
// - Short flags latched until driver disabled
// - Shared pre-warning flag above threshold
// - Shutdown latches off until pre-warning clears
// - Stall when load zero or mode stall
// - Live current scale reported
`timescale 1ns/100ps
`default_nettype none

module mds_status_flags #(
  parameter int STANDSTILL_CYCLES = mds_pkg::STANDSTILL_CLOCKS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [mds_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [mds_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [mds_pkg::DATA_W-1:0] reg_rdata,
  // Motion and enable
  input wire logic step_pulse,
  input wire logic enable_low_pin,
  // Bridge monitors
  input wire logic open_load_det_a,
  input wire logic open_load_det_b,
  input wire logic short_gnd_det_a,
  input wire logic short_gnd_det_b,
  input wire logic temp_prewarn_det,
  input wire logic temp_shutdown_det,
  // Load and current monitors
  input wire logic [mds_pkg::LOAD_W-1:0] load_measure_value,
  input wire logic load_speed_stall_det,
  input wire logic [mds_pkg::CS_W-1:0] current_scale_in,
  // Bridge control and interrupt
  output logic bridge_enable,
  output logic irq
);

  localparam int CNT_W = $clog2(STANDSTILL_CYCLES + 1);

  if (STANDSTILL_CYCLES < 2) begin : g_bad_standstill
    $error("STANDSTILL_CYCLES must be at least 2");
  end

  // Status fields must fit the data word
  if (mds_pkg::CS_LSB + mds_pkg::CS_W > mds_pkg::DATA_W) begin : g_bad_cs_field
    $error("current scale field exceeds the data word");
  end

  if (mds_pkg::IRQ_W > mds_pkg::DATA_W) begin : g_bad_irq_width
    $error("interrupt width exceeds the data word");
  end

  function automatic logic addr_hit(input logic [mds_pkg::ADDR_W-1:0] a,
                                    input logic [7:0] target);
    addr_hit = (a == target);
  endfunction : addr_hit

  // Reset release synchroniser
  // Assertion stays asynchronous, only the release is timed to the clock
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  wire logic rst_n;
  assign rst_n = rst_sync_reg;

  // Control register
  logic [mds_pkg::DATA_W-1:0] ctrl_reg;
  logic [mds_pkg::DATA_W-1:0] ctrl_next;
  logic [mds_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [mds_pkg::IRQ_W-1:0] irq_mask_next;

  always_comb begin
    ctrl_next = ctrl_reg;
    irq_mask_next = irq_mask_reg;
    if (reg_wr && addr_hit(reg_addr, mds_pkg::CTRL_ADDR)) begin
      ctrl_next = reg_wdata;
    end
    if (reg_wr && addr_hit(reg_addr, mds_pkg::IRQ_MASK_ADDR)) begin
      irq_mask_next = reg_wdata[mds_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= mds_pkg::CTRL_RESET;
      irq_mask_reg <= mds_pkg::IRQ_MASK_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  wire logic [mds_pkg::CHOPPER_TIMING_SETTING_W-1:0] chopper_timing_setting;
  wire logic load_speed_mode;
  wire logic driver_off;
  assign chopper_timing_setting = ctrl_reg[mds_pkg::CHOPPER_TIMING_SETTING_LSB +: mds_pkg::CHOPPER_TIMING_SETTING_W];
  assign load_speed_mode = ctrl_reg[mds_pkg::LSM_BIT];
  // Driver counts as disabled by zero off time or the enable pin
  assign driver_off = (chopper_timing_setting == '0) || enable_low_pin;

  // Standstill counter, saturates at the limit
  logic [CNT_W-1:0] idle_cnt_reg;
  logic [CNT_W-1:0] idle_cnt_next;
  logic standstill_reg;
  logic standstill_next;

  always_comb begin
    idle_cnt_next = idle_cnt_reg;
    // A held step level keeps the counter at zero
    if (step_pulse) begin
      idle_cnt_next = '0;
    end else if (idle_cnt_reg != CNT_W'(STANDSTILL_CYCLES)) begin
      idle_cnt_next = idle_cnt_reg + 1'b1;
    end
    standstill_next = (idle_cnt_next == CNT_W'(STANDSTILL_CYCLES));
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt_reg <= '0;
      standstill_reg <= 1'b0;
    end else begin
      idle_cnt_reg <= idle_cnt_next;
      standstill_reg <= standstill_next;
    end
  end

  // Fault and status flags
  logic open_load_a_reg;
  logic open_load_b_reg;
  logic short_gnd_phase_a;
  logic short_gnd_phase_b;
  logic temp_prewarn_reg;
  logic temp_shutdown_flag;
  logic stall_flag;
  logic [mds_pkg::CS_W-1:0] current_scale_reg;
  logic bridge_enable_reg;

  logic open_load_a_next;
  logic open_load_b_next;
  logic short_a_next;
  logic short_b_next;
  logic temp_prewarn_next;
  logic temp_shutdown_next;
  logic stall_next;
  logic [mds_pkg::CS_W-1:0] current_scale_next;
  logic bridge_enable_next;

  always_comb begin
    // Informative only, never feeds the bridge enable
    open_load_a_next = open_load_det_a;
    open_load_b_next = open_load_det_b;
    // Detection wins over the clear so no short is missed
    short_a_next = short_gnd_det_a || (short_gnd_phase_a && !driver_off);
    short_b_next = short_gnd_det_b || (short_gnd_phase_b && !driver_off);
    temp_prewarn_next = temp_prewarn_det;
    // Held until both thresholds are left behind
    temp_shutdown_next = temp_shutdown_det ||
                         (temp_shutdown_flag && temp_prewarn_det);
    stall_next = (load_measure_value == '0) ||
                 (load_speed_mode && load_speed_stall_det);
    current_scale_next = current_scale_in;
    // Next flag values, so the bridge drops in the same edge as the flag
    bridge_enable_next = !driver_off && !short_a_next && !short_b_next &&
                         !temp_shutdown_next;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      open_load_a_reg <= 1'b0;
      open_load_b_reg <= 1'b0;
      short_gnd_phase_a <= 1'b0;
      short_gnd_phase_b <= 1'b0;
      temp_prewarn_reg <= 1'b0;
      temp_shutdown_flag <= 1'b0;
      stall_flag <= 1'b0;
      current_scale_reg <= '0;
      bridge_enable_reg <= 1'b0;
    end else begin
      open_load_a_reg <= open_load_a_next;
      open_load_b_reg <= open_load_b_next;
      short_gnd_phase_a <= short_a_next;
      short_gnd_phase_b <= short_b_next;
      temp_prewarn_reg <= temp_prewarn_next;
      temp_shutdown_flag <= temp_shutdown_next;
      stall_flag <= stall_next;
      current_scale_reg <= current_scale_next;
      bridge_enable_reg <= bridge_enable_next;
    end
  end

  assign bridge_enable = bridge_enable_reg;

  // Status word assembly, reserved bits read zero
  logic [mds_pkg::DATA_W-1:0] driver_status_flags;

  always_comb begin
    driver_status_flags = '0;
    driver_status_flags[mds_pkg::STST_BIT] = standstill_reg;
    driver_status_flags[mds_pkg::OLB_BIT] = open_load_b_reg;
    driver_status_flags[mds_pkg::OLA_BIT] = open_load_a_reg;
    driver_status_flags[mds_pkg::SGB_BIT] = short_gnd_phase_b;
    driver_status_flags[mds_pkg::SGA_BIT] = short_gnd_phase_a;
    driver_status_flags[mds_pkg::OTPW_BIT] = temp_prewarn_reg;
    driver_status_flags[mds_pkg::OT_BIT] = temp_shutdown_flag;
    driver_status_flags[mds_pkg::STALL_BIT] = stall_flag;
    driver_status_flags[mds_pkg::CS_LSB +: mds_pkg::CS_W] = current_scale_reg;
  end

  // Interrupt status: rising flags, cleared by reading
  logic [mds_pkg::IRQ_W-1:0] flags_prev_reg;
  logic [mds_pkg::IRQ_W-1:0] flags_now;
  logic [mds_pkg::IRQ_W-1:0] irq_status_reg;
  logic [mds_pkg::IRQ_W-1:0] irq_status_next;
  logic irq_reg;
  logic irq_next;

  always_comb begin
    flags_now = '0;
    flags_now[mds_pkg::EV_STST] = standstill_reg;
    flags_now[mds_pkg::EV_OLA] = open_load_a_reg;
    flags_now[mds_pkg::EV_OLB] = open_load_b_reg;
    flags_now[mds_pkg::EV_SGA] = short_gnd_phase_a;
    flags_now[mds_pkg::EV_SGB] = short_gnd_phase_b;
    flags_now[mds_pkg::EV_OTPW] = temp_prewarn_reg;
    flags_now[mds_pkg::EV_OT] = temp_shutdown_flag;
    flags_now[mds_pkg::EV_STALL] = stall_flag;
    irq_status_next = irq_status_reg;
    if (reg_rd && addr_hit(reg_addr, mds_pkg::IRQ_STATUS_ADDR)) begin
      irq_status_next = '0;
    end
    // New event in the clearing cycle survives
    irq_status_next = irq_status_next | (flags_now & ~flags_prev_reg);
    // Next mask value lets a mask write act at once
    irq_next = |(irq_status_next & irq_mask_next);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_prev_reg <= '0;
      irq_status_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      flags_prev_reg <= flags_now;
      irq_status_reg <= irq_status_next;
      irq_reg <= irq_next;
    end
  end

  assign irq = irq_reg;

  // Read data, one cycle after the strobe; status read has no side effect
  logic [mds_pkg::DATA_W-1:0] rdata_reg;
  logic [mds_pkg::DATA_W-1:0] rdata_next;

  always_comb begin
    rdata_next = '0;
    if (reg_rd) begin
      case (reg_addr)
        mds_pkg::STATUS_ADDR: rdata_next = driver_status_flags;
        mds_pkg::CTRL_ADDR: rdata_next = ctrl_reg;
        mds_pkg::IRQ_STATUS_ADDR: begin
          rdata_next = {{(mds_pkg::DATA_W-mds_pkg::IRQ_W){1'b0}}, irq_status_reg};
        end
        mds_pkg::IRQ_MASK_ADDR: begin
          rdata_next = {{(mds_pkg::DATA_W-mds_pkg::IRQ_W){1'b0}}, irq_mask_reg};
        end
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule : mds_status_flags

`default_nettype wire

// ===== bench/mds_bridge_model.sv
`timescale 1ns/100ps
`default_nettype none

module mds_bridge_model (
  // Bridge state
  input wire logic bridge_enable,
  input wire logic [5:0] fault_set,
  // Monitor outputs
  output logic open_load_det_a,
  output logic open_load_det_b,
  output logic short_gnd_det_a,
  output logic short_gnd_det_b,
  output logic temp_prewarn_det,
  output logic temp_shutdown_det
);
  // A short is only seen while the bridge drives; once off it reads low
  assign {temp_shutdown_det, temp_prewarn_det, short_gnd_det_b, short_gnd_det_a,
    open_load_det_b, open_load_det_a} =
    fault_set & {2'h3, {2{bridge_enable}}, 2'h3};
endmodule : mds_bridge_model

`default_nettype wire

// ===== bench/mds_status_checker.sv
`timescale 1ns/100ps
`default_nettype none

module mds_status_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Monitors
  input wire logic open_load_det_a,
  input wire logic open_load_det_b,
  input wire logic short_gnd_det_a,
  input wire logic short_gnd_det_b,
  input wire logic temp_prewarn_det,
  input wire logic temp_shutdown_det,
  input wire logic [9:0] load_measure_value,
  input wire logic [4:0] current_scale_in,
  // Bridge
  input wire logic bridge_enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire logic rd_st = reg_rd && reg_addr == mds_pkg::STATUS_ADDR;

  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside read");
  chk_short_off: assert property (short_gnd_det_a || short_gnd_det_b |=> !bridge_enable)
    else $error("bridge on after short");
  chk_hot_off: assert property (temp_shutdown_det |=> !bridge_enable)
    else $error("bridge on after shutdown");
  chk_hot_hold: assert property (temp_shutdown_det ##1 temp_prewarn_det [*2] |->
    !bridge_enable)
    else $error("bridge on while still warm");
  chk_ol_flags: assert property (rd_st |=> reg_rdata[30:29] ==
    {$past(open_load_det_b, 2), $past(open_load_det_a, 2)})
    else $error("open load bits wrong");
  chk_prewarn_flag: assert property (rd_st |=>
    reg_rdata[26] == $past(temp_prewarn_det, 2))
    else $error("prewarn bit wrong");
  chk_stall_flag: assert property (rd_st && load_measure_value == 10'h0 &&
    $past(load_measure_value) == 10'h0 |=> reg_rdata[24])
    else $error("stall bit low at zero load");
  chk_cs_live: assert property (rd_st && $stable(current_scale_in) |=>
    reg_rdata[20:16] == $past(current_scale_in))
    else $error("current scale wrong");
  chk_reserved_zero: assert property (rd_st |=> reg_rdata[23:21] == 3'h0 &&
    reg_rdata[15:0] == 16'h0)
    else $error("reserved bits not zero");

  cover property (rd_st ##1 reg_rdata[27]);
  cover property (temp_shutdown_det ##1 temp_prewarn_det);
  cover property (rd_st && load_measure_value == 10'h0);
endmodule : mds_status_checker

bind mds_status_flags mds_status_checker u_chk (.core_clk(core_clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .open_load_det_a(open_load_det_a), .open_load_det_b(open_load_det_b),
  .short_gnd_det_a(short_gnd_det_a), .short_gnd_det_b(short_gnd_det_b),
  .temp_prewarn_det(temp_prewarn_det), .temp_shutdown_det(temp_shutdown_det),
  .load_measure_value(load_measure_value), .current_scale_in(current_scale_in),
  .bridge_enable(bridge_enable));

`default_nettype wire

// ===== bench/motor_driver_status_flags_bench.sv
`timescale 1ns/100ps
`default_nettype none

module motor_driver_status_flags_bench;
  localparam int ST = 16;
  logic core_clk, rst_b, reg_wr, reg_rd, step_pulse, enable_low_pin, stall_det;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [9:0] load;
  logic [4:0] cs;
  logic [5:0] fault;
  logic ola, olb, sga, sgb, tpw, tsd, bridge_enable, irq;
  int err_count = 0;
  int n_tests = 0;

  mds_status_flags #(.STANDSTILL_CYCLES(ST)) uut (.core_clk(core_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .step_pulse(step_pulse), .enable_low_pin(enable_low_pin),
    .open_load_det_a(ola), .open_load_det_b(olb), .short_gnd_det_a(sga),
    .short_gnd_det_b(sgb), .temp_prewarn_det(tpw), .temp_shutdown_det(tsd),
    .load_measure_value(load), .load_speed_stall_det(stall_det), .current_scale_in(cs),
    .bridge_enable(bridge_enable), .irq(irq));
  mds_bridge_model u_model (.bridge_enable(bridge_enable), .fault_set(fault),
    .open_load_det_a(ola), .open_load_det_b(olb), .short_gnd_det_a(sga),
    .short_gnd_det_b(sgb), .temp_prewarn_det(tpw), .temp_shutdown_det(tsd));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  // Gap cycle after each strobe so no strobe is reassigned in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
    cyc(1); reg_wr <= 1'b0; cyc(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    reg_addr <= a; reg_rd <= 1'b1;
    cyc(1); reg_rd <= 1'b0;
    @(negedge core_clk); v = reg_rdata; cyc(1);
  endtask : rd
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic t_regs;
    rd(mds_pkg::CTRL_ADDR, d); chk(d, mds_pkg::CTRL_RESET, "ctrl reset");
    rd(mds_pkg::IRQ_MASK_ADDR, d); chk(d, 32'h0, "mask reset");
    rd(8'h10, d); chk(d, 32'h0, "unmapped read");
    // Let the standstill count run out after reset
    cyc(ST);
    rd(mds_pkg::STATUS_ADDR, d); chk(d, 32'h8015_0000, "idle status");
    wr(mds_pkg::STATUS_ADDR, 32'hffff_ffff);
    rd(mds_pkg::STATUS_ADDR, d); chk(d, 32'h8015_0000, "status after write");
    $display("done regs");
  endtask : t_regs
  task automatic t_short;
    wr(mds_pkg::CTRL_ADDR, 32'h1); wr(mds_pkg::IRQ_MASK_ADDR, 32'h08); cyc(2);
    chk(bridge_enable, 1'b1, "bridge on");
    fault <= 6'h04; cyc(3); chk(bridge_enable, 1'b0, "short keeps bridge off");
    fault <= 6'h00; rd(mds_pkg::STATUS_ADDR, d); chk(d[27], 1'b1, "short a latched");
    chk(irq, 1'b1, "irq raised");
    rd(mds_pkg::IRQ_STATUS_ADDR, d); chk(d[3], 1'b1, "irq bit");
    chk(irq, 1'b0, "irq cleared by read");
    enable_low_pin <= 1'b1; cyc(3); rd(mds_pkg::STATUS_ADDR, d);
    chk(d[27], 1'b0, "pin clears short");
    enable_low_pin <= 1'b0; cyc(3); fault <= 6'h08; cyc(3); fault <= 6'h00;
    rd(mds_pkg::STATUS_ADDR, d); chk(d[28], 1'b1, "short b latched");
    wr(mds_pkg::CTRL_ADDR, 32'h0); cyc(2); rd(mds_pkg::STATUS_ADDR, d);
    chk(d[28], 1'b0, "timing zero clears short");
    wr(mds_pkg::CTRL_ADDR, 32'h1); cyc(2);
    $display("done short");
  endtask : t_short
  task automatic t_ol;
    // One slow step so the open-load bits are read while moving
    fault <= 6'h03; step_pulse <= 1'b1; cyc(1); step_pulse <= 1'b0; cyc(2);
    chk(bridge_enable, 1'b1, "open load leaves bridge");
    rd(mds_pkg::STATUS_ADDR, d); chk(d[30:29], 2'b11, "open load bits");
    chk(irq, 1'b0, "masked event"); fault <= 6'h00; cyc(2);
    $display("done open load");
  endtask : t_ol
  task automatic t_temp;
    fault <= 6'h30; cyc(3); chk(bridge_enable, 1'b0, "hot bridge off");
    rd(mds_pkg::STATUS_ADDR, d); chk(d[26:25], 2'b11, "hot bits");
    fault <= 6'h10; cyc(3); chk(bridge_enable, 1'b0, "still warm");
    rd(mds_pkg::STATUS_ADDR, d); chk(d[26:25], 2'b11, "shutdown held");
    fault <= 6'h00; cyc(3); chk(bridge_enable, 1'b1, "cooled bridge on");
    rd(mds_pkg::STATUS_ADDR, d); chk(d[26:25], 2'b00, "cooled bits");
    $display("done temp");
  endtask : t_temp
  task automatic t_stall;
    load <= 10'h0; cyc(2); rd(mds_pkg::STATUS_ADDR, d); chk(d[24], 1'b1, "zero load");
    load <= 10'h3ff; stall_det <= 1'b1; cyc(2);
    rd(mds_pkg::STATUS_ADDR, d); chk(d[24], 1'b0, "mode off");
    wr(mds_pkg::CTRL_ADDR, 32'h11); cyc(2);
    rd(mds_pkg::STATUS_ADDR, d); chk(d[24], 1'b1, "mode stall");
    stall_det <= 1'b0; wr(mds_pkg::CTRL_ADDR, 32'h1);
    $display("done stall");
  endtask : t_stall
  task automatic t_stst;
    // Last idle cycle before the limit, then the second one at it
    cs <= 5'h0a; step_pulse <= 1'b1; cyc(1); step_pulse <= 1'b0; cyc(ST - 1);
    rd(mds_pkg::STATUS_ADDR, d); chk(d[31], 1'b0, "moving");
    chk(d[20:16], 5'h0a, "live scale");
    rd(mds_pkg::STATUS_ADDR, d); chk(d[31], 1'b1, "standstill");
    $display("done standstill");
  endtask : t_stst

  initial begin
    rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
    step_pulse = 1'b0; enable_low_pin = 1'b0; stall_det = 1'b0;
    load = 10'h3ff; cs = 5'h15; fault = 6'h00;
    cyc(20); rst_b <= 1'b1; cyc(3);
    t_regs; t_short; t_ol; t_temp; t_stall; t_stst;
    tally_and_finish;
  end
  initial begin
    cyc(3000); err_count++;
    tally_and_finish;
  end
endmodule : motor_driver_status_flags_bench

`default_nettype wire
